/* File: design/cdc_map.vh */
// Constants for the debug entry and clock switch block.
`ifndef CDC_MAP_VH
`define CDC_MAP_VH
`define CDC_CTRL_MONITOR_BIT 4
`define CDC_CTRL_WIDTH 6
`define CDC_CTRL_RESET 6'h00
`define CDC_ABORT_NONE 2'h0
`define CDC_ABORT_DEBUG 2'h1
`define CDC_ABORT_MEMORY 2'h2
`define CDC_MODE_WIDTH 5
`define CDC_MODE_RESET 5'h00
`endif

/* File: design/cdc_sync3.v */
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/1ns
module cdc_sync3 (
  input wire clk_in,
  input wire reset_n_in,
  input wire async_in,
  output reg level_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // The first stage is read only by the second; a change counts once the
  // second and third stages agree, filtering single-cycle glitches.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule // cdc_sync3

/* File: design/cdc_debug_ctrl.v */
// Debug state entry, halt/monitor choice and core clock switching.
// What this block does
// - Break high during a load or store marks it watchpointed.
// - Halt acknowledge asserts whenever debug state is entered.
// - Breakpointed instructions are tagged, not run; entry at Execute.
// - Control bit 4 picks halt or abort on break and watch.
// - Branch or PC write before a tagged instruction cancels it.
// - Exception before Execute cancels breakpoint; refill flags it again.
// - Watchpoint taken only after the current instruction fully completes.
// - Watchpoint with pending exception enters debug in exception mode.
// - Halt request is synchronised, then taken at instruction end.
// - Synchronised request during coprocessor busy-wait enters debug at once.
// - In debug, request and sequential outputs show internal cycles.
// - In debug, aborts and interrupts are ignored.
// - Other memory outputs may change asynchronously in halt mode.
// - Monitor mode aborts; abort status tells debug from memory.
// - In monitor mode the memory interface behaves normally.
// - Ack as soon as entry is taken, in either clock phase, then debug clock at next falling edge.
// - Exit after final instruction and resume instruction; back to memory.
// - Serial test clocks core on debug clock; memory clock held low.
// - Debug clock pulses while halted, or in serial test in Run-Test/Idle under chain 0 INTEST.
// - With enable low, break and request ignored, ack forced low.
// - The clock driving the core is output on a clock pin.
`timescale 1ns/1ns
`include "cdc_map.vh"
module cdc_debug_ctrl (
  input wire clk_in,
  input wire reset_n_in,
  input wire mem_clock_in,
  input wire test_clock_in,
  input wire ext_break_in,
  input wire halt_request_in,
  input wire halt_logic_enable_in,
  input wire [`CDC_CTRL_WIDTH-1:0] debug_ctrl_in,
  input wire fetch_valid_in,
  input wire data_access_in,
  input wire execute_tagged_in,
  input wire instr_end_in,
  input wire flush_in,
  input wire exception_pending_in,
  input wire [`CDC_MODE_WIDTH-1:0] exception_mode_in,
  input wire cp_busy_wait_in,
  input wire abort_in,
  input wire irq_in,
  input wire mem_abort_in,
  input wire core_mem_request_n_in,
  input wire core_sequential_in,
  input wire restart_selected_in,
  input wire intest_chain0_in,
  input wire run_test_idle_in,
  input wire serial_test_in,
  output reg halt_ack_out,
  output reg fetch_tag_out,
  output reg cancel_instr_out,
  output reg take_abort_out,
  output reg [1:0] abort_status_out,
  output reg [`CDC_MODE_WIDTH-1:0] debug_mode_out,
  output reg abort_pass_out,
  output reg irq_pass_out,
  output reg mem_request_n_out,
  output reg sequential_cycle_out,
  output reg internal_halt_clock_out,
  output reg selected_clock_out,
  output reg halt_clock_select_out
);
  // Debug state sequence: run, wait for the memory clock fall, halted on
  // the debug clock, then wait for a memory clock rise to resume.
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT_FALL = 2'h1;
  localparam ST_HALT = 2'h2;
  localparam ST_RESYNC = 2'h3;

  // Sampled pins, their edge history and the debug state.
  wire mclk_s;
  wire tck_s;
  wire brk_s;
  wire req_s;
  reg mclk_prev_q;
  reg tck_prev_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg watch_pend_q;
  reg req_pend_q;
  reg enable_q;
  wire mclk_rise;
  wire mclk_fall;
  wire tck_rise;
  wire monitor;
  wire in_halt;
  wire enter_now;
  wire halt_gate;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers. The request is async, and both clocks and the
  // break line are sampled rather than used as clocks.
  // Each sampled line lags its pin by three to four system clocks, so a
  // memory clock faster than a quarter of the system clock is not seen.
  // Memory clock, sampled for its edges.
  cdc_sync3 u_sync_mclk (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(mem_clock_in),
    .level_out(mclk_s)
  );
  // Test clock, sampled for its edges.
  cdc_sync3 u_sync_tck (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(test_clock_in),
    .level_out(tck_s)
  );
  // External break line from the outside comparators.
  cdc_sync3 u_sync_brk (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(ext_break_in),
    .level_out(brk_s)
  );
  // Halt request; only this filtered copy reaches the entry logic.
  cdc_sync3 u_sync_req (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(halt_request_in),
    .level_out(req_s)
  );

  // Edge history of the sampled clocks.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mclk_prev_q <= 1'b0;
      tck_prev_q <= 1'b0;
      enable_q <= 1'b0;
    end else begin
      mclk_prev_q <= mclk_s;
      tck_prev_q <= tck_s;
      enable_q <= halt_logic_enable_in;
    end
  end

  assign mclk_rise = mclk_s & ~mclk_prev_q;
  assign mclk_fall = ~mclk_s & mclk_prev_q;
  assign tck_rise = tck_s & ~tck_prev_q;
  assign monitor = debug_ctrl_in[`CDC_CTRL_MONITOR_BIT];
  assign in_halt = (state_q != ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Break tagging and watchpoint capture, both on the memory clock rise.
  // A tag is lost by a flush; refetch after an exception re-tags it.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fetch_tag_out <= 1'b0;
      watch_pend_q <= 1'b0;
      req_pend_q <= 1'b0;
    end else begin
      fetch_tag_out <= 1'b0;
      if (mclk_rise && enable_q && brk_s && fetch_valid_in) begin
        fetch_tag_out <= 1'b1;
      end
      // A new watch event wins over the clear at instruction end.
      if (mclk_rise && enable_q && brk_s && data_access_in) begin
        watch_pend_q <= 1'b1;
      end else if (instr_end_in || !enable_q) begin
        watch_pend_q <= 1'b0;
      end
      if (req_s && enable_q && !in_halt) begin
        req_pend_q <= 1'b1;
      end else if (enter_now || !enable_q) begin
        req_pend_q <= 1'b0;
      end
    end
  end

  // Entry conditions: tagged instruction at Execute unless flushed,
  // watchpoint at instruction end, request at end or during cp busy-wait.
  wire brk_hit = execute_tagged_in & ~flush_in & enable_q;
  wire watch_hit = watch_pend_q & instr_end_in;
  wire req_hit = req_pend_q & (instr_end_in | cp_busy_wait_in);
  wire halt_by_watch_exc = watch_hit & exception_pending_in;
  assign enter_now = (state_q == ST_RUN) & enable_q &
    (req_hit | ((brk_hit | watch_hit) & (~monitor | halt_by_watch_exc)));

  // The memory side must see internal cycles from the very edge at which
  // the acknowledge rises, so the bus gate also looks at the entry term.
  assign halt_gate = in_halt | enter_now;

  ////////////////////////////////////////////////////////////////////////
  // Monitor abort path and the abort status.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      take_abort_out <= 1'b0;
      cancel_instr_out <= 1'b0;
      abort_status_out <= `CDC_ABORT_NONE;
      debug_mode_out <= `CDC_MODE_RESET;
    end else begin
      take_abort_out <= 1'b0;
      cancel_instr_out <= brk_hit | (req_hit & cp_busy_wait_in);
      if (monitor && !in_halt && (brk_hit || watch_hit) &&
          !halt_by_watch_exc) begin
        take_abort_out <= 1'b1;
        abort_status_out <= `CDC_ABORT_DEBUG;
      end else if (mem_abort_in && !in_halt) begin
        abort_status_out <= `CDC_ABORT_MEMORY;
      end
      if (enter_now && halt_by_watch_exc) begin
        debug_mode_out <= exception_mode_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock switch sequence: ack at entry in either phase, switch at falling edge,
  // resume after the restart instruction at a memory clock rise.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (enter_now) begin
          state_d = ST_WAIT_FALL;
        end
      end
      ST_WAIT_FALL: begin
        if (mclk_fall) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (restart_selected_in) begin
          state_d = ST_RESYNC;
        end
      end
      ST_RESYNC: begin
        if (mclk_rise) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // State register. Dropping the enable abandons debug state at once;
  // the core is then on the memory clock again, whatever the debugger
  // was doing, which is the price of a hard disable.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_RUN;
    end else if (!enable_q) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs. The debug clock follows the test clock only while halted, or
  // in serial test under chain 0 INTEST in Run-Test/Idle; a sampled copy
  // is coarse but glitch free, which is what matters for the core.
  wire halt_clk_en = (state_q == ST_HALT) |
    (serial_test_in & intest_chain0_in & run_test_idle_in);

  // Acknowledge and clock choice. The acknowledge rises with the entry
  // term so that it leads the clock switch by at least two system clocks.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      halt_ack_out <= 1'b0;
      internal_halt_clock_out <= 1'b0;
      halt_clock_select_out <= 1'b0;
      selected_clock_out <= 1'b0;
    end else begin
      halt_ack_out <= enable_q & halt_gate;
      internal_halt_clock_out <= halt_clk_en & tck_s & ~tck_rise;
      halt_clock_select_out <= (state_q == ST_HALT) | serial_test_in;
      selected_clock_out <= ((state_q == ST_HALT) | serial_test_in) ?
        (halt_clk_en & tck_s) : mclk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory side. Only the request and sequential lines are steadied here;
  // the core's address and other memory outputs may move at any time while
  // halted, so the memory controller must not act on them then.
  // Aborts and interrupts are held off for the whole of debug state.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_request_n_out <= 1'b1;
      sequential_cycle_out <= 1'b0;
      abort_pass_out <= 1'b0;
      irq_pass_out <= 1'b0;
    end else begin
      mem_request_n_out <= halt_gate ? 1'b1 : core_mem_request_n_in;
      sequential_cycle_out <= halt_gate ? 1'b0 : core_sequential_in;
      abort_pass_out <= abort_in & ~halt_gate;
      irq_pass_out <= irq_in & ~halt_gate;
    end
  end
endmodule // cdc_debug_ctrl

/* File: tb/cdc_dbg_checker.sv */
// Checker for the debug entry and clock switch outputs.
`timescale 1ns/1ns
`include "cdc_map.vh"
module cdc_dbg_checker (
  input wire clk_in,
  input wire reset_n_in,
  input wire halt_logic_enable_in,
  input wire [`CDC_CTRL_WIDTH-1:0] debug_ctrl_in,
  input wire run_test_idle_in,
  input wire halt_ack_out,
  input wire take_abort_out,
  input wire [1:0] abort_status_out,
  input wire mem_request_n_out,
  input wire sequential_cycle_out,
  input wire irq_pass_out,
  input wire internal_halt_clock_out,
  input wire halt_clock_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire mon = debug_ctrl_in[`CDC_CTRL_MONITOR_BIT];
  // Debug entry is the rise of the acknowledge.
  sequence s_entry;
    $rose(halt_ack_out);
  endsequence
  AST_ACK_OFF: assert property (!halt_logic_enable_in[*3] |->
    !halt_ack_out) else $error("ack while disabled");
  AST_ACK_EN: assert property (s_entry |->
    $past(halt_logic_enable_in, 2)) else $error("entry while disabled");
  AST_IDLE_BUS: assert property (s_entry |->
    mem_request_n_out && !sequential_cycle_out) else $error("bus busy");
  AST_IRQ_GATE: assert property (s_entry |=>
    !irq_pass_out) else $error("irq passed in debug");
  AST_CLK_SW: assert property (s_entry ##0 !mon |->
    ##[1:24] halt_clock_select_out) else $error("no clock switch");
  AST_SEL_ACK: assert property (halt_clock_select_out |->
    halt_ack_out) else $error("debug clock without ack");
  AST_ABT_MON: assert property (take_abort_out |->
    $past(mon) && !halt_ack_out) else $error("abort in halt mode");
  AST_ABT_ST: assert property ($rose(take_abort_out) |->
    ##[0:2] abort_status_out == `CDC_ABORT_DEBUG) else $error("status");
  AST_INTERNAL_HALT_CLOCK: assert property (!run_test_idle_in[*6] |->
    !internal_halt_clock_out) else $error("debug clock outside idle");
endmodule // cdc_dbg_checker
////////////////////////////////////////////////////////////////////////
bind cdc_debug_ctrl cdc_dbg_checker cdc_dbg_checker_i (.*);

/* File: tb/cdc_far_model.sv */
// Far side: memory clock, gated test clock and external break logic.
`timescale 1ns/1ns
module cdc_far_model (
  input wire tck_run_in,
  input wire break_req_in,
  output reg mem_clock_out,
  output reg test_clock_out,
  output reg ext_break_out
);
  reg armed_q;
  initial {mem_clock_out, test_clock_out, ext_break_out, armed_q} = 0;
  // The memory clock free-runs at a 500 ns period.
  always #250 mem_clock_out = ~mem_clock_out;
  // The test clock rests low outside debug frames.
  always #200 test_clock_out = tck_run_in ? ~test_clock_out : 1'b0;
  // Data is valid at the fall, so break follows at the next rise.
  always @(negedge mem_clock_out) armed_q <= break_req_in;
  always @(posedge mem_clock_out) ext_break_out <= armed_q;
endmodule // cdc_far_model

/* File: tb/cdc_debug_ctrl_tb.sv */
// Self-checking bench for the debug entry and clock switch block.
`timescale 1ns/1ns
`include "cdc_map.vh"
module cdc_debug_ctrl_tb;
  reg clk_in = 0, reset_n_in = 0, halt_request_in, halt_logic_enable_in;
  reg fetch_valid_in, data_access_in, execute_tagged_in, instr_end_in;
  reg flush_in, exception_pending_in, cp_busy_wait_in, abort_in, irq_in;
  reg mem_abort_in, core_mem_request_n_in, core_sequential_in;
  reg restart_selected_in, intest_chain0_in, run_test_idle_in;
  reg serial_test_in, tck_run, brk_req, pa = 0;
  reg [5:0] debug_ctrl_in;
  reg [4:0] exception_mode_in, emode;
  reg [15:0] lf = 16'hC00A;
  reg [7:0] q[$];
  wire mem_clock_in, test_clock_in, ext_break_in, halt_ack_out;
  wire fetch_tag_out, cancel_instr_out, take_abort_out, abort_pass_out;
  wire irq_pass_out, mem_request_n_out, sequential_cycle_out;
  wire internal_halt_clock_out, selected_clock_out, halt_clock_select_out;
  wire [1:0] abort_status_out;
  wire [4:0] debug_mode_out;
  integer fail_count = 0, compares = 0, m, tags = 0;
  cdc_debug_ctrl cdc_debug_ctrl_i (.*);
  cdc_far_model cdc_far_model_i (.tck_run_in(tck_run),
    .break_req_in(brk_req), .mem_clock_out(mem_clock_in),
    .test_clock_out(test_clock_in), .ext_break_out(ext_break_in));
  always #25 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////
  task chk(input [7:0] s, input [7:0] e);
    compares = compares + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  // Waits a bounded time for the acknowledge to reach a level.
  // Samples at the falling edge, where the outputs have settled.
  task wait_ack(input v);
    integer i;
    @(negedge clk_in);
    for (i = 0; i < 80 && halt_ack_out !== v; i = i + 1) @(negedge clk_in);
    chk(halt_ack_out, v);
    @(posedge clk_in);
  endtask
  function [15:0] lfsr_next(input [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Clocks a debug frame in Run-Test/Idle, then selects resume.
  task leave;
    tick(1);
    {intest_chain0_in, run_test_idle_in, tck_run} <= 3'h7;
    tick(40);
    restart_selected_in <= 1;
    wait_ack(0);
    {restart_selected_in, intest_chain0_in, run_test_idle_in} <= 3'h0;
    tck_run <= 0;
    tick(4);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Each result pops the oldest note; a halt entry is 1, an abort 2.
  always @(negedge clk_in) begin
    if (halt_ack_out === 1'b1 && pa !== 1'b1)
      chk(8'h01, q.size() ? q.pop_front() : 8'hFF);
    if (take_abort_out === 1'b1)
      chk(8'h02, q.size() ? q.pop_front() : 8'hFF);
    if (take_abort_out === 1'b1) chk(cancel_instr_out, 1);
    if (halt_ack_out === 1'b1)
      chk({mem_request_n_out, sequential_cycle_out, irq_pass_out,
        abort_pass_out}, 8'h08);
    if (fetch_tag_out === 1'b1) tags = tags + 1;
    pa = halt_ack_out;
  end
  // Random traffic on the core cycle type, aborts and interrupts.
  always @(posedge clk_in) begin
    lf <= lfsr_next(lf);
    {abort_in, irq_in, core_mem_request_n_in, core_sequential_in} <= lf[3:0];
  end
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    {halt_request_in, fetch_valid_in, data_access_in, execute_tagged_in,
      instr_end_in, flush_in, exception_pending_in, cp_busy_wait_in,
      mem_abort_in, brk_req, restart_selected_in, intest_chain0_in,
      run_test_idle_in, serial_test_in, tck_run, debug_ctrl_in,
      exception_mode_in} = 0;
    halt_logic_enable_in = 1;
    tick(16);
    reset_n_in <= 1;
    tick(4);
    // Request waits for the end of the current instruction.
    halt_request_in <= 1;
    tick(8);
    chk(halt_ack_out, 0);
    q.push_back(1);
    instr_end_in <= 1;
    tick(1);
    instr_end_in <= 0;
    wait_ack(1);
    halt_request_in <= 0;
    leave;
    // Busy-wait on a coprocessor is cut short by the request.
    {cp_busy_wait_in, halt_request_in} <= 2'h3;
    q.push_back(1);
    wait_ack(1);
    {cp_busy_wait_in, halt_request_in} <= 2'h0;
    leave;
    // With the logic disabled the request is dropped.
    {halt_logic_enable_in, halt_request_in, instr_end_in} <= 3'h3;
    tick(1);
    instr_end_in <= 0;
    tick(30);
    chk(halt_ack_out, 0);
    halt_request_in <= 0;
    tick(6);
    halt_logic_enable_in <= 1;
    tick(4);
    // Breakpoint in halt mode, then in monitor mode.
    for (m = 0; m < 2; m = m + 1) begin
      debug_ctrl_in <= m ? 6'h10 : 6'h00;
      {fetch_valid_in, brk_req} <= 2'h3;
      tick(25);
      {fetch_valid_in, brk_req} <= 2'h0;
      chk(tags > m, 1);
      q.push_back(m ? 2 : 1);
      execute_tagged_in <= 1;
      tick(1);
      execute_tagged_in <= 0;
      if (m) tick(12);
      else wait_ack(1);
      if (m) chk(abort_status_out, `CDC_ABORT_DEBUG);
      else leave;
    end
    // A flush in the same cycle cancels the tagged instruction.
    {execute_tagged_in, flush_in} <= 2'h3;
    tick(1);
    {execute_tagged_in, flush_in} <= 2'h0;
    tick(12);
    chk({halt_ack_out, take_abort_out}, 0);
    // Watchpoint with a pending exception waits for instruction end.
    emode = lf[4:0];
    exception_mode_in <= emode;
    {exception_pending_in, data_access_in, brk_req} <= 3'h7;
    tick(25);
    {data_access_in, brk_req} <= 2'h0;
    chk(halt_ack_out, 0);
    q.push_back(1);
    instr_end_in <= 1;
    tick(1);
    instr_end_in <= 0;
    wait_ack(1);
    chk(debug_mode_out, emode);
    exception_pending_in <= 0;
    leave;
    chk(q.size(), 0);
    end_sim;
  end
endmodule // cdc_debug_ctrl_tb
